// *** src/sanm_mdio_regs.v ***
`timescale 1ns/1ns
`include "sanm_defines.vh"

module sanm_mdio_regs
(
   input  wire        core_clk,
   input  wire        reset_n,
   input  wire        mdc,
   input  wire        mdio_in,
   output wire        mdio_out,
   output wire        mdio_oe,
   input  wire [4:0]  phy_addr,
   input  wire [15:0] lp_ability_word,
   input  wire        lp_ability_valid,
   input  wire [15:0] np_rx_word,
   input  wire        np_rx_valid,
   input  wire        page_received,
   input  wire        an_complete,
   output wire        negotiation_done_irq
);

   // ==========================================================
   // Frame states, one-hot
   localparam [7:0] S_IDLE  = 8'h01;
   localparam [7:0] S_START = 8'h02;
   localparam [7:0] S_HDR   = 8'h04;
   localparam [7:0] S_RTA   = 8'h08;
   localparam [7:0] S_RDATA = 8'h10;
   localparam [7:0] S_WTA   = 8'h20;
   localparam [7:0] S_WDATA = 8'h40;
   localparam [7:0] S_SKIP  = 8'h80;

   wire        mdc_s;
   wire        mdio_s;
   reg         mdc_prev_reg;
   wire        mdc_rise;

   reg [7:0]   state_reg;
   reg [4:0]   cnt_reg;
   reg [11:0]  hdr_reg;
   reg [15:0]  shift_reg;
   reg [4:0]   addr_reg;
   reg         out_reg;
   reg         oe_reg;
   reg         wr_pulse_reg;
   reg         rd_exp_pulse;

   reg         lp_link_reg;
   reg         lp_ack_reg;
   reg         lp_duplex_reg;
   reg [1:0]   lp_speed_reg;
   reg [15:0]  np_rx_reg;
   reg         page_rx_reg;
   reg         irq_en_reg;
   reg         irq_stat_reg;
   reg         irq_stat_next;
   reg [15:0]  rd_data;

   wire [11:0] hdr_full;
   wire [1:0]  hdr_op;
   wire [4:0]  hdr_phy;
   wire [4:0]  hdr_reg_addr;
   wire        addr_hit;

   // ==========================================================
   // Management pins cross into the core clock
   sanm_sync
   #(
      .WIDTH (2)
   )
   u_pin_sync
   (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in ({mdc, mdio_in}),
      .sync_out ({mdc_s, mdio_s})
   );

   // Edge finder reads the second stage only
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         mdc_prev_reg <= 1'b1;
      else
         mdc_prev_reg <= mdc_s;
   end

   assign mdc_rise = mdc_s & ~mdc_prev_reg;

   // ==========================================================
   // Header decode; the last address bit arrives on this edge
   assign hdr_full     = {hdr_reg[10:0], mdio_s};
   assign hdr_op       = hdr_full[11:10];
   assign hdr_phy      = hdr_full[9:5];
   assign hdr_reg_addr = hdr_full[4:0];
   assign addr_hit     = (hdr_reg_addr == `SANM_ADDR_PARTNER_ABILITY) |
                         (hdr_reg_addr == `SANM_ADDR_NEG_EXPANSION) |
                         (hdr_reg_addr == `SANM_ADDR_NP_TRANSMIT) |
                         (hdr_reg_addr == `SANM_ADDR_NP_RECEIVE) |
                         (hdr_reg_addr == `SANM_ADDR_EXT_STATUS) |
                         (hdr_reg_addr == `SANM_ADDR_IRQ_CONTROL);

   // Read image of every register in this bank
   always @*
   begin
      case (hdr_reg_addr)
         `SANM_ADDR_PARTNER_ABILITY:
            rd_data = {lp_link_reg, lp_ack_reg, 1'b0, lp_duplex_reg,
                       lp_speed_reg, 9'h000, 1'b1};
         `SANM_ADDR_NEG_EXPANSION:
            rd_data = {13'h0000, 1'b1, page_rx_reg, 1'b0};
         `SANM_ADDR_NP_TRANSMIT:
            rd_data = `SANM_NP_TRANSMIT_RST;
         `SANM_ADDR_NP_RECEIVE:
            rd_data = np_rx_reg;
         `SANM_ADDR_EXT_STATUS:
            rd_data = `SANM_EXT_STATUS_VAL;
         `SANM_ADDR_IRQ_CONTROL:
            rd_data = {14'h0000, irq_stat_reg, irq_en_reg};
         default:
            rd_data = 16'h0000;
      endcase
   end

   // ==========================================================
   // Clause 22 frame engine, advanced on each mdc rising edge.
   // Foreign addresses are skipped so a second slave can answer.
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg    <= S_IDLE;
         cnt_reg      <= 5'h00;
         hdr_reg      <= 12'h000;
         shift_reg    <= 16'h0000;
         addr_reg     <= 5'h00;
         out_reg      <= 1'b1;
         oe_reg       <= 1'b0;
         wr_pulse_reg <= 1'b0;
         rd_exp_pulse <= 1'b0;
      end
      else
      begin
         wr_pulse_reg <= 1'b0;
         rd_exp_pulse <= 1'b0;
         if (mdc_rise)
         begin
            case (state_reg)
               S_IDLE:
               begin
                  // Preamble may be suppressed; first zero opens
                  if (!mdio_s)
                     state_reg <= S_START;
               end
               S_START:
               begin
                  cnt_reg   <= 5'h00;
                  state_reg <= mdio_s ? S_HDR : S_IDLE;
               end
               S_HDR:
               begin
                  hdr_reg <= hdr_full;
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == `SANM_HDR_BITS - 5'h01)
                  begin
                     cnt_reg  <= 5'h00;
                     addr_reg <= hdr_reg_addr;
                     if (hdr_phy == phy_addr && addr_hit &&
                         hdr_op == `SANM_OP_READ)
                     begin
                        shift_reg    <= rd_data;
                        rd_exp_pulse <= (hdr_reg_addr ==
                                         `SANM_ADDR_NEG_EXPANSION);
                        state_reg    <= S_RTA;
                     end
                     else if (hdr_phy == phy_addr && addr_hit &&
                              hdr_op == `SANM_OP_WRITE)
                        state_reg <= S_WTA;
                     else
                        state_reg <= S_SKIP;
                  end
               end
               S_RTA:
               begin
                  // Second turnaround bit is driven low by us
                  oe_reg    <= 1'b1;
                  out_reg   <= 1'b0;
                  state_reg <= S_RDATA;
               end
               S_RDATA:
               begin
                  if (cnt_reg == `SANM_DATA_BITS)
                  begin
                     oe_reg    <= 1'b0;
                     out_reg   <= 1'b1;
                     state_reg <= S_IDLE;
                  end
                  else
                  begin
                     out_reg   <= shift_reg[15];
                     shift_reg <= {shift_reg[14:0], 1'b0};
                     cnt_reg   <= cnt_reg + 5'h01;
                  end
               end
               S_WTA:
               begin
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == `SANM_TA_BITS - 5'h01)
                  begin
                     cnt_reg   <= 5'h00;
                     state_reg <= S_WDATA;
                  end
               end
               S_WDATA:
               begin
                  shift_reg <= {shift_reg[14:0], mdio_s};
                  cnt_reg   <= cnt_reg + 5'h01;
                  if (cnt_reg == `SANM_DATA_BITS - 5'h01)
                  begin
                     wr_pulse_reg <= 1'b1;
                     state_reg    <= S_IDLE;
                  end
               end
               S_SKIP:
               begin
                  // Ride out another slave's frame so its data is
                  // never mistaken for a start pattern
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == `SANM_SKIP_BITS - 5'h01)
                     state_reg <= S_IDLE;
               end
               default:
               begin
                  state_reg <= S_IDLE;
                  oe_reg    <= 1'b0;
               end
            endcase
         end
      end
   end

   assign mdio_out = out_reg;
   assign mdio_oe  = oe_reg;

   // ==========================================================
   // Partner words captured from the negotiation logic
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lp_link_reg   <= `SANM_PA_LINK_RST;
         lp_ack_reg    <= 1'b0;
         lp_duplex_reg <= 1'b0;
         lp_speed_reg  <= `SANM_PA_SPEED_RST;
         np_rx_reg     <= `SANM_NP_RECEIVE_RST;
      end
      else
      begin
         if (lp_ability_valid)
         begin
            lp_link_reg   <= lp_ability_word[`SANM_PA_LINK];
            lp_ack_reg    <= lp_ability_word[`SANM_PA_ACK];
            lp_duplex_reg <= lp_ability_word[`SANM_PA_DUPLEX];
            lp_speed_reg  <= lp_ability_word[`SANM_PA_SPEED_HI:
                                             `SANM_PA_SPEED_LO];
         end
         if (np_rx_valid)
            np_rx_reg <= np_rx_word;
      end
   end

   // ==========================================================
   // Page-received flag; a new page beats the read clear
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         page_rx_reg <= 1'b0;
      else if (page_received)
         page_rx_reg <= 1'b1;
      else if (rd_exp_pulse)
         page_rx_reg <= 1'b0;
   end

   // ==========================================================
   // Interrupt control; only enable and status take writes
   always @*
   begin
      irq_stat_next = irq_stat_reg;
      if (wr_pulse_reg && addr_reg == `SANM_ADDR_IRQ_CONTROL &&
          !shift_reg[`SANM_IRQ_STATUS])
         irq_stat_next = 1'b0;
      if (an_complete)
         irq_stat_next = 1'b1;
      if (!irq_en_reg)
         irq_stat_next = 1'b0;
   end

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_en_reg   <= `SANM_IRQ_ENABLE_RST;
         irq_stat_reg <= 1'b0;
      end
      else
      begin
         if (wr_pulse_reg && addr_reg == `SANM_ADDR_IRQ_CONTROL)
            irq_en_reg <= shift_reg[`SANM_IRQ_ENABLE];
         irq_stat_reg <= irq_stat_next;
      end
   end

   // Interrupt pin is the status flop itself
   assign negotiation_done_irq = irq_stat_reg;

endmodule

// *** src/sanm_defines.vh ***
`ifndef SANM_DEFINES_VH
`define SANM_DEFINES_VH

// ==========================================================
// Register addresses (clause 22, five bits)
`define SANM_ADDR_PARTNER_ABILITY   5'h05
`define SANM_ADDR_NEG_EXPANSION     5'h06
`define SANM_ADDR_NP_TRANSMIT       5'h07
`define SANM_ADDR_NP_RECEIVE        5'h08
`define SANM_ADDR_EXT_STATUS        5'h0f
`define SANM_ADDR_IRQ_CONTROL       5'h10

// ==========================================================
// Partner ability field positions
`define SANM_PA_LINK                15
`define SANM_PA_ACK                 14
`define SANM_PA_DUPLEX              12
`define SANM_PA_SPEED_HI            11
`define SANM_PA_SPEED_LO            10
`define SANM_PA_LINK_RST            1'h1
`define SANM_PA_SPEED_RST           2'h0

// ==========================================================
// Expansion and interrupt control field positions
`define SANM_EXP_NP_ABLE            2
`define SANM_EXP_PAGE_RX            1
`define SANM_IRQ_STATUS             1
`define SANM_IRQ_ENABLE             0
`define SANM_IRQ_ENABLE_RST         1'h1

// ==========================================================
// Constant register images and the next-page receive reset value
`define SANM_NP_TRANSMIT_RST        16'h2001
`define SANM_NP_RECEIVE_RST         16'h0000
`define SANM_EXT_STATUS_VAL         16'h8000

// ==========================================================
// Management frame fields and bit counts
`define SANM_OP_READ                2'h2
`define SANM_OP_WRITE               2'h1
`define SANM_HDR_BITS               5'h0c
`define SANM_TA_BITS                5'h02
`define SANM_DATA_BITS              5'h10
`define SANM_SKIP_BITS              5'h12

`endif

// *** src/sanm_sync.v ***
`timescale 1ns/1ns

// ==========================================================
// Two-stage synchroniser, one lane per bit
module sanm_sync
#(
   parameter WIDTH = 1
)
(
   input  wire             core_clk,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // First stage feeds only the second stage
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_reg <= {WIDTH{1'b1}};
         sync_reg <= {WIDTH{1'b1}};
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule

// *** verification/sanm_mdio_regs_assertions.sv ***
`timescale 1ns/1ns
// ==========================================================
// Management pin and interrupt output checks
module sanm_mdio_regs_chk
(
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        mdc,
   input wire logic        mdio_in,
   input wire logic        mdio_out,
   input wire logic        mdio_oe,
   input wire logic [4:0]  phy_addr,
   input wire logic [15:0] lp_ability_word,
   input wire logic        lp_ability_valid,
   input wire logic [15:0] np_rx_word,
   input wire logic        np_rx_valid,
   input wire logic        page_received,
   input wire logic        an_complete,
   input wire logic        negotiation_done_irq
);
   logic       mdc_q;
   logic [7:0] since_mdc;
   logic [4:0] oe_rises;
   wire        mdc_rise = mdc && !mdc_q;

   // Age of the last raw mdc rise; saturates so idle time stays large
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mdc_q     <= 1'b1;
         since_mdc <= 8'hff;
         oe_rises  <= 5'h00;
      end
      else
      begin
         mdc_q     <= mdc;
         since_mdc <= mdc_rise ? 8'h00 : since_mdc + {7'h00, since_mdc != 8'hff};
         oe_rises  <= !mdio_oe ? 5'h00 : oe_rises + {4'h0, mdc_rise};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // Read turnaround and data phase
   sequence s_drive_start;
      $rose(mdio_oe);
   endsequence
   sequence s_turn;
      !mdio_out ##1 mdio_oe [*8];
   endsequence
   property p_ta_low;
      s_drive_start |-> s_turn;
   endproperty
   a_ta_low: assert property (p_ta_low)
      else $error("turnaround not driven low");
   property p_oe_cause;
      s_drive_start |-> since_mdc <= 8'h06;
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("drive began away from an mdc rise");
   property p_oe_len;
      $fell(mdio_oe) |-> oe_rises == 5'h11;
   endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("drive did not last seventeen mdc periods");
   property p_out_idle;
      !mdio_oe |-> mdio_out;
   endproperty
   a_out_idle: assert property (p_out_idle)
      else $error("data out not high while released");
   property p_out_hold;
      mdio_oe && $changed(mdio_out) |-> since_mdc <= 8'h06;
   endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("read bit changed mid period");

   // ==========================================================
   // Interrupt output
   property p_irq_set;
      $rose(negotiation_done_irq) |-> $past(an_complete);
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("interrupt rose without completion");
   property p_irq_clear;
      $fell(negotiation_done_irq) |-> since_mdc <= 8'h0a;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt fell without a write");
   property p_irq_hold;
      negotiation_done_irq && since_mdc > 8'h0c |=> negotiation_done_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped while bus idle");
endmodule

bind sanm_mdio_regs sanm_mdio_regs_chk i_chk
(
   .core_clk            (core_clk),
   .reset_n             (reset_n),
   .mdc                 (mdc),
   .mdio_in             (mdio_in),
   .mdio_out            (mdio_out),
   .mdio_oe             (mdio_oe),
   .phy_addr            (phy_addr),
   .lp_ability_word     (lp_ability_word),
   .lp_ability_valid    (lp_ability_valid),
   .np_rx_word          (np_rx_word),
   .np_rx_valid         (np_rx_valid),
   .page_received       (page_received),
   .an_complete         (an_complete),
   .negotiation_done_irq(negotiation_done_irq)
);

// *** verification/sanm_mgmt_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// Station manager: clause 22 frames, mdc at 160 ns
module sanm_mgmt_model
(
   input  wire logic core_clk,
   input  wire logic mdio_line,
   output logic      mdc,
   output logic      host_bit,
   output logic      host_en
);
   // Clock parked high and line released outside frames
   initial
   begin
      mdc = 1'b1;
      host_bit = 1'b1;
      host_en = 1'b0;
   end

   // One idle one, then ST OP PHY REG TA DATA, MSB first
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] fr;
      fr = {2'b01, op, phy, rg, 2'b10, wd};
      rd = 16'h0000;
      for (int i = -1; i < 32; i++)
      begin
         @(posedge core_clk);
         #1;
         mdc = 1'b0;
         host_en = (i < 14) || (op == 2'h1);
         host_bit = (i < 0) ? 1'b1 : fr[31-i];
         repeat (4) @(posedge core_clk);
         // Sample late in the low phase, well after the bit settled
         #1;
         if (i >= 16)
            rd = {rd[14:0], mdio_line};
         mdc = 1'b1;
         repeat (3) @(posedge core_clk);
      end
      @(posedge core_clk);
      #1;
      host_en = 1'b0;
      repeat (12) @(posedge core_clk);
   endtask
endmodule

// *** verification/sanm_mdio_regs_tb_top.sv ***
`timescale 1ns/1ns
// ==========================================================
// Register bank bench
module sanm_mdio_regs_tb_top;
   logic        core_clk;
   logic        reset_n;
   logic        mdc;
   logic        mdio_line;
   logic        host_bit;
   logic        host_en;
   logic        mdio_out;
   logic        mdio_oe;
   logic        irq;
   logic [3:0]  ev_sel;
   logic [15:0] ev_word;
   int          n_fail;
   int          cmp_count;
   logic [4:0]  addr_t [6] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h0f, 5'h10};
   logic [15:0] rst_t [6] = '{16'h8001, 16'h0004, 16'h2001, 16'h0000,
                              16'h8000, 16'h0001};

   // Pulled-up shared data line
   assign mdio_line = mdio_oe ? mdio_out : (host_en ? host_bit : 1'b1);

   sanm_mdio_regs i_dut
   (
      .core_clk            (core_clk),
      .reset_n             (reset_n),
      .mdc                 (mdc),
      .mdio_in             (mdio_line),
      .mdio_out            (mdio_out),
      .mdio_oe             (mdio_oe),
      .phy_addr            (5'h03),
      .lp_ability_word     (ev_word),
      .lp_ability_valid    (ev_sel[0]),
      .np_rx_word          (ev_word),
      .np_rx_valid         (ev_sel[1]),
      .page_received       (ev_sel[2]),
      .an_complete         (ev_sel[3]),
      .negotiation_done_irq(irq)
   );

   sanm_mgmt_model i_mgmt
   (
      .core_clk (core_clk),
      .mdio_line(mdio_line),
      .mdc      (mdc),
      .host_bit (host_bit),
      .host_en  (host_en)
   );

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [4:0] phy, input logic [4:0] rg,
      input logic [15:0] exp);
      logic [15:0] v;
      i_mgmt.xfer(`SANM_OP_READ, phy, rg, 16'h0000, v);
      chk(v, exp);
   endtask

   task automatic wr(input logic [4:0] rg, input logic [15:0] d);
      logic [15:0] v;
      i_mgmt.xfer(`SANM_OP_WRITE, 5'h03, rg, d, v);
   endtask

   // One-cycle event from the negotiation side
   task automatic ev(input logic [3:0] sel, input logic [15:0] w);
      @(posedge core_clk);
      #1;
      ev_sel = sel;
      ev_word = w;
      @(posedge core_clk);
      #1;
      ev_sel = 4'h0;
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      for (int i = 0; i < 6; i++)
         rchk(5'h03, addr_t[i], rst_t[i]);
      $display("reset values done");
   endtask

   // Writes of all ones must not stick; foreign frames go unanswered
   task automatic t_readonly;
      for (int i = 0; i < 5; i++)
      begin
         wr(addr_t[i], 16'hffff);
         rchk(5'h03, addr_t[i], rst_t[i]);
      end
      rchk(5'h03, 5'h09, 16'hffff);
      rchk(5'h04, 5'h05, 16'hffff);
      $display("read-only writes done");
   endtask

   // Every speed code, duplex and link captured from the base page
   task automatic t_ability;
      ev(4'h1, 16'hffff);
      rchk(5'h03, 5'h05, 16'hdc01);
      ev(4'h1, 16'h0800);
      rchk(5'h03, 5'h05, 16'h0801);
      ev(4'h1, 16'h0400);
      rchk(5'h03, 5'h05, 16'h0401);
      ev(4'h1, 16'h1000);
      rchk(5'h03, 5'h05, 16'h1001);
      $display("partner ability done");
   endtask

   task automatic t_next_page;
      ev(4'h2, 16'ha5a5);
      rchk(5'h03, 5'h08, 16'ha5a5);
      ev(4'h2, 16'h5a5a);
      rchk(5'h03, 5'h08, 16'h5a5a);
      rchk(5'h03, 5'h07, 16'h2001);
      ev(4'h4, 16'h0000);
      rchk(5'h03, 5'h06, 16'h0006);
      rchk(5'h03, 5'h06, 16'h0004);
      $display("pages done");
   endtask

   // Set, write-one keep, write-zero clear, then disabled
   task automatic t_irq;
      ev(4'h8, 16'h0000);
      chk({15'h0000, irq}, 16'h0001);
      wr(5'h10, 16'h0003);
      rchk(5'h03, 5'h10, 16'h0003);
      wr(5'h10, 16'h0001);
      chk({15'h0000, irq}, 16'h0000);
      ev(4'h8, 16'h0000);
      wr(5'h10, 16'h0002);
      chk({15'h0000, irq}, 16'h0000);
      ev(4'h8, 16'h0000);
      rchk(5'h03, 5'h10, 16'h0000);
      wr(5'h10, 16'hffff);
      rchk(5'h03, 5'h10, 16'h0001);
      $display("interrupt done");
   endtask

   // ==========================================================
   // Clock, main sequence and watchdog
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial
   begin
      reset_n = 1'b0;
      ev_sel = 4'h0;
      ev_word = 16'h0000;
      n_fail = 0;
      cmp_count = 0;
      repeat (3) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      repeat (2) @(posedge core_clk);
      t_reset;
      t_readonly;
      t_ability;
      t_next_page;
      t_irq;
      test_done;
   end

   // About 34 frames of 280 cycles each; far above that means a hang
   initial
   begin
      #2000000;
      n_fail++;
      test_done;
   end
endmodule
